// [hdl/ewp_ctrl.sv]
// Host controller that loads, programs and polls the parallel EEPROM module
`timescale 1ns/1ps
module ewp_ctrl #(
    parameter int         WC_CYCLES  = ewp_pkg::WC_DEF, // Longest write cycle, clocks
    parameter logic [7:0] UNLOCK_CMD = 8'ha0            // Third unlock byte
) (
    input  wire  logic                 hclk,          // Bus clock, 20 MHz
    input  wire  logic                 hresetn,       // Async reset, active low
    input  wire  logic                 hsel,          // Slave select
    input  wire  logic [31:0]          haddr,         // Byte address
    input  wire  logic [1:0]           htrans,        // Transfer type
    input  wire  logic                 hwrite,        // Write when high
    input  wire  logic [2:0]           hsize,         // Word only
    input  wire  logic [31:0]          hwdata,        // Write data
    input  wire  logic                 hready,        // Bus ready
    output logic                       hreadyout,     // Always ready
    output logic                       hresp,         // Always OKAY
    output logic [31:0]                hrdata,        // Read data
    output ewp_pkg::ewp_pin_type       pins,          // Memory-side pins
    input  wire  logic [7:0]           data_in,       // Data lines in
    input  wire  logic                 rdy_busy_in    // Pulled-up busy line
);
    import ewp_pkg::*;

    ewp_state_type state_r, state_nxt;
    ewp_op_type    op_r, op_nxt;
    ewp_tmr_type   tmr_r, tmr_nxt;
    ewp_tmr_type   wc_r, wc_nxt;
    ewp_tmr_type   hold_r, rp_r, gap_r;
    ewp_pin_type   pins_r, pins_nxt;
    logic [2:0]    idx_r, idx_nxt;
    logic [3:0]    cfg_r;
    logic [18:0]   addr_r;
    logic [7:0]    wdata_r, rdata_r, rdata_nxt;
    logic          last_b7_r, last_b7_nxt;
    logic          page_r, page_nxt;
    logic          done_r, refused_r, late_r, tmo_r;
    logic [7:0]    din_meta_r, din_sync_r;
    logic          rdy_meta_r, rdy_sync_r;
    logic          dp_wr_r;
    logic [7:0]    dp_addr_r;
    logic [31:0]   hrdata_r;

    // Bus decode
    wire         ap_valid  = hsel & hready & htrans[1];
    wire  [7:0]  ap_addr   = {haddr[7:2], 2'b00};
    wire         busy      = (state_r != ST_IDLE);
    wire         wr_cfg    = dp_wr_r & (dp_addr_r == REG_CFG);
    wire         wr_addr   = dp_wr_r & (dp_addr_r == REG_ADDR);
    wire         wr_wdata  = dp_wr_r & (dp_addr_r == REG_WDATA);
    wire         wr_cmd    = dp_wr_r & (dp_addr_r == REG_CMD);
    wire         wr_status = dp_wr_r & (dp_addr_r == REG_STATUS);
    wire  [2:0]  cmd       = hwdata[2:0];
    wire  [1:0]  wait_mode = cfg_r[CFG_WAIT_LSB +: 2];
    wire         sdp_en    = cfg_r[CFG_SDP_BIT];
    wire         res_pin   = cfg_r[CFG_RES_BIT] | (hold_r != '0);
    wire         res_ok    = res_pin & (rp_r == '0);
    wire         cmd_ok    = wr_cmd & ~busy & res_ok;
    wire         cmd_bad   = (wr_cmd & (busy | ~res_ok))
                             | ((wr_addr | wr_wdata) & busy);
    wire         win_lost  = (state_r == ST_IDLE) & page_r & (gap_r == '0);
    wire         byte_done = (state_r == ST_LATCH) & (tmr_r == TMR_ONE);
    wire         op_done;

    // One-hot active-low select; only one die is ever picked
    wire  [3:0]  die_n     = ~(4'h1 << addr_r[18:17]);

    // Status word seen by software
    wire  [7:0]  status_w  = {tmo_r, page_r, res_ok, rdy_sync_r, late_r,
                              refused_r, done_r, busy};

    // Unlock and cancel words, then the user byte at index three
    function automatic logic [24:0] seq_word(input ewp_op_type op,
                                             input logic [2:0] idx,
                                             input logic [16:0] ua,
                                             input logic [7:0] ud,
                                             input logic [7:0] unl);
        logic [24:0] w;
        w = {ua, ud};
        unique case (idx)
            3'h0: w = {A_5555, D_AA};
            3'h1: w = {A_2AAA, D_55};
            3'h2: w = (op == OP_CANCEL) ? {A_5555, D_80} : {A_5555, unl};
            3'h3: w = (op == OP_CANCEL) ? {A_5555, D_AA} : {ua, ud};
            3'h4: w = {A_2AAA, D_55};
            3'h5: w = {A_5555, D_20};
            default: w = {ua, ud};
        endcase
        return w;
    endfunction

    wire  [24:0] cur_word = seq_word(op_r, idx_r, addr_r[16:0], wdata_r, UNLOCK_CMD);
    wire         seq_end  = (op_r == OP_CANCEL) ? (idx_r == IDX_LAST_CANCEL)
                                                : (idx_r == IDX_USER);
    assign op_done = (state_nxt == ST_IDLE) & busy & (op_r != OP_LOAD || page_nxt);

    // Sequencer: next state, timers and pin levels
    always_comb begin
        state_nxt   = state_r;
        op_nxt      = op_r;
        tmr_nxt     = (tmr_r != '0) ? tmr_r - TMR_ONE : tmr_r;
        wc_nxt      = (wc_r != '0) ? wc_r - TMR_ONE : wc_r;
        idx_nxt     = idx_r;
        page_nxt    = page_r;
        rdata_nxt   = rdata_r;
        last_b7_nxt = last_b7_r;
        pins_nxt.addr                  = addr_r[16:0];
        pins_nxt.die_select_n          = 4'hf;
        pins_nxt.oe_n                  = 1'b1;
        pins_nxt.we_n                  = 1'b1;
        pins_nxt.write_protect_reset_n = res_pin;
        pins_nxt.dout                  = cur_word[7:0];
        pins_nxt.doe                   = 8'h00;
        unique case (state_r)
            ST_IDLE: begin
                if (win_lost) begin
                    // Host missed the load window; the device commits on its own
                    page_nxt  = 1'b0;
                    state_nxt = ST_WIN;
                    tmr_nxt   = C_BL;
                end else if (cmd_ok && cmd == CMD_LOAD) begin
                    op_nxt    = OP_LOAD;
                    idx_nxt   = (sdp_en && !page_r) ? 3'h0 : IDX_USER;
                    state_nxt = ST_SETUP;
                end else if (cmd_ok && cmd == CMD_CANCEL) begin
                    op_nxt    = OP_CANCEL;
                    idx_nxt   = 3'h0;
                    state_nxt = ST_SETUP;
                end else if (cmd_ok && cmd == CMD_READ) begin
                    op_nxt    = OP_READ;
                    state_nxt = ST_RACC;
                    tmr_nxt   = C_RD;
                end else if (cmd_ok && cmd == CMD_COMMIT && page_r) begin
                    // Leaving both strobes high lets the device start its write
                    page_nxt  = 1'b0;
                    state_nxt = ST_WIN;
                    tmr_nxt   = C_BL;
                end
            end
            ST_SETUP: begin
                // Select and address settle before the write strobe falls
                pins_nxt.addr         = cur_word[24:8];
                pins_nxt.die_select_n = die_n;
                pins_nxt.doe          = 8'hff;
                state_nxt             = ST_STROBE;
                tmr_nxt               = C_WP;
            end
            ST_STROBE: begin
                pins_nxt.addr         = cur_word[24:8];
                pins_nxt.die_select_n = die_n;
                pins_nxt.we_n         = 1'b0;
                pins_nxt.doe          = 8'hff;
                if (tmr_r == TMR_ONE) begin
                    state_nxt = ST_LATCH;
                    tmr_nxt   = C_DL;
                end
            end
            ST_LATCH: begin
                // Data stays driven past the rising strobe for the latch time
                pins_nxt.addr         = cur_word[24:8];
                pins_nxt.die_select_n = die_n;
                pins_nxt.doe          = 8'hff;
                if (tmr_r == TMR_ONE) begin
                    state_nxt = ST_GAP;
                    tmr_nxt   = C_GAP;
                end
            end
            ST_GAP: begin
                if (tmr_r <= TMR_ONE) begin
                    if (!seq_end) begin
                        idx_nxt   = idx_r + 3'h1;
                        state_nxt = ST_SETUP;
                    end else if (op_r == OP_LOAD) begin
                        page_nxt    = 1'b1;
                        last_b7_nxt = wdata_r[7];
                        state_nxt   = ST_IDLE;
                    end else begin
                        // Cancel writes program nothing; only the window is waited
                        state_nxt = ST_WIN;
                        tmr_nxt   = C_BL;
                    end
                end
            end
            ST_WIN: begin
                if (tmr_r <= TMR_ONE) begin
                    state_nxt = (op_r == OP_CANCEL) ? ST_IDLE : ST_WSTART;
                    tmr_nxt   = C_DW;
                end
            end
            ST_WSTART: begin
                if (tmr_r <= TMR_ONE) begin
                    state_nxt = ST_WDONE;
                    wc_nxt    = ewp_tmr_type'(WC_CYCLES);
                end
            end
            ST_WDONE: begin
                if (wc_r == '0) begin
                    state_nxt = ST_IDLE;
                end else if (wait_mode == WAIT_RDY && rdy_sync_r) begin
                    state_nxt = ST_IDLE;
                end else if (wait_mode == WAIT_POLL) begin
                    op_nxt    = OP_POLL;
                    state_nxt = ST_RACC;
                    tmr_nxt   = C_RD;
                end
            end
            ST_RACC: begin
                pins_nxt.die_select_n = die_n;
                pins_nxt.oe_n         = 1'b0;
                if (tmr_r <= TMR_ONE) begin
                    state_nxt = ST_RDONE;
                end
            end
            ST_RDONE: begin
                // Latch the synchronised read data; a poll goes back to waiting while bit 7 still differs
                rdata_nxt = din_sync_r;
                if (op_r == OP_POLL && din_sync_r[7] != last_b7_r) begin
                    state_nxt = ST_WDONE;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers; pins leave flops so no strobe can glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r   <= ST_IDLE;
            op_r      <= OP_NONE;
            tmr_r     <= '0;
            wc_r      <= '0;
            idx_r     <= 3'h0;
            page_r    <= 1'b0;
            rdata_r   <= 8'h00;
            last_b7_r <= 1'b0;
            pins_r    <= '{addr: 17'h00000, die_select_n: 4'hf, oe_n: 1'b1, we_n: 1'b1,
                           write_protect_reset_n: 1'b0, dout: 8'h00, doe: 8'h00};
        end else begin
            state_r   <= state_nxt;
            op_r      <= op_nxt;
            tmr_r     <= tmr_nxt;
            wc_r      <= wc_nxt;
            idx_r     <= idx_nxt;
            page_r    <= page_nxt;
            rdata_r   <= rdata_nxt;
            last_b7_r <= last_b7_nxt;
            pins_r    <= pins_nxt;
        end
    end

    // Reset-pin hold after data, release wait, and page window timers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= '0;
            rp_r   <= C_RP;
            gap_r  <= '0;
        end else begin
            hold_r <= byte_done ? ewp_tmr_type'(WC_CYCLES)
                                : ((hold_r != '0) ? hold_r - TMR_ONE : hold_r);
            rp_r   <= !res_pin ? C_RP : ((rp_r != '0) ? rp_r - TMR_ONE : rp_r);
            gap_r  <= byte_done ? C_LOAD : ((gap_r != '0) ? gap_r - TMR_ONE : gap_r);
        end
    end

    // Two-flop synchronisers for the pins coming back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            din_meta_r <= 8'h00;
            din_sync_r <= 8'h00;
            rdy_meta_r <= 1'b1;
            rdy_sync_r <= 1'b1;
        end else begin
            din_meta_r <= data_in;
            din_sync_r <= din_meta_r;
            rdy_meta_r <= rdy_busy_in;
            rdy_sync_r <= rdy_meta_r;
        end
    end

    // Bus address phase and read data; reads answer with zero wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r  <= 32'h00000000;
        end else begin
            dp_wr_r   <= ap_valid & hwrite;
            dp_addr_r <= ap_addr;
            if (ap_valid && !hwrite) begin
                unique case (ap_addr)
                    REG_CFG:    hrdata_r <= {28'h0000000, cfg_r};
                    REG_ADDR:   hrdata_r <= {13'h0000, addr_r};
                    REG_WDATA:  hrdata_r <= {24'h000000, wdata_r};
                    REG_STATUS: hrdata_r <= {24'h000000, status_w};
                    REG_RDATA:  hrdata_r <= {24'h000000, rdata_r};
                    default:    hrdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // Software registers; address and data refused while a sequence runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r   <= 4'h0;
            addr_r  <= 19'h00000;
            wdata_r <= 8'h00;
        end else begin
            if (wr_cfg) begin
                cfg_r <= hwdata[3:0];
            end
            if (wr_addr && !busy) begin
                addr_r <= hwdata[18:0];
            end
            if (wr_wdata && !busy) begin
                wdata_r <= hwdata[7:0];
            end
        end
    end

    // Sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r    <= 1'b0;
            refused_r <= 1'b0;
            late_r    <= 1'b0;
            tmo_r     <= 1'b0;
        end else begin
            done_r    <= op_done | (done_r & ~(wr_status & hwdata[ST_DONE]));
            refused_r <= cmd_bad | (refused_r & ~(wr_status & hwdata[ST_REFUSED]));
            late_r    <= win_lost | (late_r & ~(wr_status & hwdata[ST_LATE]));
            tmo_r     <= (state_r == ST_WDONE && wc_r == '0 && wait_mode != WAIT_TIMER)
                         | (tmo_r & ~(wr_status & hwdata[ST_TIMEOUT]));
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign pins      = pins_r;

endmodule

// [hdl/ewp_pkg.sv]
// Constants, types and carriers for the EEPROM page-write host controller
// What this block does
// - Next page byte within 30 us
// - Reset high 10 ms after last data
// - Three unlock bytes precede each protected write
// - Six writes cancel software protection
// - Internal write ends within 10 ms
// - Wait write start time before polling
// - Byte loads spaced 0.95 to 30 us
// - Hold data latch time per byte
// - Wait 200 us after reset release
// - At most one die select low
package ewp_pkg;

    // Clock and timing figures, slowest grade
    localparam int CLK_NS      = 50;
    localparam int T_WP_NS     = 350;
    localparam int T_DL_NS     = 400;
    localparam int BYTE_LOAD_SPACING_NS    = 950;
    localparam int T_ACC_NS    = 200;
    localparam int T_DW_NS     = 250;
    localparam int T_BL_US     = 200;
    localparam int T_RP_US     = 200;
    localparam int T_LOAD_US   = 30;
    localparam int T_WC_MS     = 10;
    localparam int SYNC_LAG    = 3;

    localparam int TMR_W = 18;
    typedef logic [TMR_W-1:0] ewp_tmr_type;

    // Least times round up, the load window rounds down
    localparam ewp_tmr_type C_WP   = ewp_tmr_type'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam ewp_tmr_type C_DL   = ewp_tmr_type'((T_DL_NS + CLK_NS - 1) / CLK_NS);
    localparam ewp_tmr_type C_GAP  = ewp_tmr_type'((BYTE_LOAD_SPACING_NS + CLK_NS - 1) / CLK_NS
                                     - (T_WP_NS + CLK_NS - 1) / CLK_NS
                                     - (T_DL_NS + CLK_NS - 1) / CLK_NS);
    localparam ewp_tmr_type C_RD   = ewp_tmr_type'((T_ACC_NS + CLK_NS - 1) / CLK_NS
                                     + SYNC_LAG);
    localparam ewp_tmr_type C_DW   = ewp_tmr_type'((T_DW_NS + CLK_NS - 1) / CLK_NS);
    localparam ewp_tmr_type C_BL   = ewp_tmr_type'((T_BL_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam ewp_tmr_type C_RP   = ewp_tmr_type'((T_RP_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam ewp_tmr_type C_LOAD = ewp_tmr_type'((T_LOAD_US * 1000) / CLK_NS);
    localparam int          WC_DEF = T_WC_MS * 1000000 / CLK_NS;
    localparam ewp_tmr_type TMR_ONE = ewp_tmr_type'(1);

    // Register byte offsets
    localparam logic [7:0] REG_CFG    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_CMD    = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA  = 8'h14;

    // Configuration fields
    localparam int CFG_SDP_BIT  = 0;
    localparam int CFG_RES_BIT  = 1;
    localparam int CFG_WAIT_LSB = 2;
    localparam logic [1:0] WAIT_TIMER = 2'h0;
    localparam logic [1:0] WAIT_POLL  = 2'h1;
    localparam logic [1:0] WAIT_RDY   = 2'h2;

    // Status fields
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_LATE    = 3;
    localparam int ST_RDY     = 4;
    localparam int ST_RES_OK  = 5;
    localparam int ST_PAGE    = 6;
    localparam int ST_TIMEOUT = 7;

    // Commands
    localparam logic [2:0] CMD_LOAD   = 3'h1;
    localparam logic [2:0] CMD_COMMIT = 3'h2;
    localparam logic [2:0] CMD_READ   = 3'h3;
    localparam logic [2:0] CMD_CANCEL = 3'h4;

    // Protection sequence words
    localparam logic [16:0] A_5555 = 17'h05555;
    localparam logic [16:0] A_2AAA = 17'h02aaa;
    localparam logic [7:0]  D_AA   = 8'haa;
    localparam logic [7:0]  D_55   = 8'h55;
    localparam logic [7:0]  D_80   = 8'h80;
    localparam logic [7:0]  D_20   = 8'h20;
    localparam logic [2:0]  IDX_USER = 3'h3;
    localparam logic [2:0]  IDX_LAST_CANCEL = 3'h5;
    localparam int          PAGE_BITS = 7;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_SETUP  = 4'h1,
        ST_STROBE = 4'h3,
        ST_LATCH  = 4'h2,
        ST_GAP    = 4'h6,
        ST_WIN    = 4'h7,
        ST_WSTART = 4'h5,
        ST_WDONE  = 4'h4,
        ST_RACC   = 4'hc,
        ST_RDONE  = 4'hd
    } ewp_state_type;

    typedef enum logic [2:0] {
        OP_NONE, OP_LOAD, OP_CANCEL, OP_READ, OP_POLL
    } ewp_op_type;

    // Pins driven toward the memory module
    typedef struct packed {
        logic [16:0] addr;
        logic [3:0]  die_select_n;
        logic        oe_n;
        logic        we_n;
        logic        write_protect_reset_n;
        logic [7:0]  dout;
        logic [7:0]  doe;
    } ewp_pin_type;

endpackage

// [sim/ewp_ctrl_tb.sv]
// Self-checking bench for the EEPROM page-write host controller
`timescale 1ns/1ps
module ewp_ctrl_tb;
    import ewp_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire         hready;
    wire [31:0]  hrdata;
    ewp_pin_type pins;
    logic [7:0]  dq;
    logic        busy;
    logic [31:0] q;
    int          err_count = 0;
    int          checks_done = 0;
    wire [7:0]   data_in = |pins.doe ? pins.dout : dq; // Shared data wire
    always #25 hclk = ~hclk;
    ewp_ctrl #(.WC_CYCLES(200)) ewp_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata), .pins(pins),
        .data_in(data_in), .rdy_busy_in(~busy));
    ewp_mem_model ewp_mem_model_i (.pins(pins), .dq(dq), .busy(busy));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One single bus transfer; read data lands in q
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // Poll a status bit, bounded so a stuck bit gives up after 3000 reads
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        do begin
            xfer(REG_STATUS, 1'b0, 32'h0);
            n++;
        end while (q[b] !== v && n < 3000);
    endtask
    task automatic op(input logic [31:0] a, input logic [7:0] d, input logic [2:0] c);
        xfer(REG_ADDR, 1'b1, a);
        xfer(REG_WDATA, 1'b1, {24'h0, d});
        xfer(REG_CMD, 1'b1, {29'h0, c});
        wait_st(ST_BUSY, 1'b0);
    endtask
    task automatic finish_test();
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        chk(pins.write_protect_reset_n, 32'h0);
        hresetn <= 1'b1;
        xfer(8'h3c, 1'b0, 32'h0);
        chk(q, 32'h0);
        xfer(REG_CMD, 1'b1, {29'h0, CMD_READ});
        xfer(REG_STATUS, 1'b0, 32'h0);
        chk(q[ST_REFUSED], 32'h1);
        // Each completion mode: two bytes out of order, commit, read back
        for (int m = 0; m < 3; m++) begin
            xfer(REG_CFG, 1'b1, 32'h2 | (m << 2));
            wait_st(ST_RES_OK, 1'b1);
            op(32'h2007f + m * 128, 8'h3c ^ 8'(m), CMD_LOAD);
            op(32'h20000 + m * 128, 8'hc3 ^ 8'(m), CMD_LOAD);
            op(32'h20000 + m * 128, 8'h0, CMD_COMMIT);
            chk(q[ST_TIMEOUT], 32'h0);
            chk(ewp_mem_model_i.mem[32'h2007f + m * 128], 8'h3c ^ 8'(m));
            op(32'h20000 + m * 128, 8'h0, CMD_READ);
            xfer(REG_RDATA, 1'b0, 32'h0);
            chk(q, {24'h0, 8'hc3 ^ 8'(m)});
        end
        // Protected write, then cancel leaves nothing programmed
        xfer(REG_CFG, 1'b1, 32'hb);
        op(32'h40010, 8'h81, CMD_LOAD);
        op(32'h0, 8'h0, CMD_COMMIT);
        chk(ewp_mem_model_i.mem[32'h40010], 32'h81);
        chk(ewp_mem_model_i.prot, 32'h1);
        op(32'h0, 8'h0, CMD_CANCEL);
        chk(ewp_mem_model_i.mem.exists(32'h5555), 32'h0);
        chk(ewp_mem_model_i.prot, 32'h0);
        // Missed load window: controller flags it and programs on its own
        xfer(REG_CFG, 1'b1, 32'ha);
        op(32'h60020, 8'h66, CMD_LOAD);
        repeat (700) @(posedge hclk);
        xfer(REG_STATUS, 1'b0, 32'h0);
        chk(q[ST_LATE], 32'h1);
        wait_st(ST_BUSY, 1'b0);
        chk(ewp_mem_model_i.mem[32'h60020], 32'h66);
        finish_test();
    end
    // Watchdog: the run needs about 30000 cycles, so 80000 means a hang
    initial begin
        #4ms;
        err_count++;
        finish_test();
    end
endmodule
bind ewp_ctrl ewp_monitor ewp_monitor_i (.hclk(hclk), .hresetn(hresetn), .pins(pins),
    .rdy_busy_in(rdy_busy_in));

// [sim/ewp_mem_model.sv]
// Behavioural memory module: four dies, page load, busy line and polling
`timescale 1ns/1ps
module ewp_mem_model (
    input  wire ewp_pkg::ewp_pin_type pins, // Controller pins
    output logic [7:0]                dq,   // Data the memory drives
    output logic                      busy  // High while busy line is pulled low
);
    import ewp_pkg::*;
    logic [7:0] mem [int];
    logic [7:0] pg [int];
    logic [7:0] last_d;
    logic [7:0] junk = 8'h5a;
    logic       prot = 1'b0;
    logic       unl = 1'b0;
    int         key;
    realtime    t_fall;
    realtime    t_last;
    wire        sel = pins.die_select_n != 4'hf;
    wire [1:0]  die = {~&pins.die_select_n[3:2], ~pins.die_select_n[1] | ~pins.die_select_n[3]};
    wire        seq = (pins.addr == A_5555 || pins.addr == A_2AAA)
                      && pins.dout inside {D_AA, D_55, D_80, D_20, 8'ha0};
    initial busy = 1'b0;
    // Released lines float, so show a pattern that changes every cycle
    always #50 junk = ~junk;
    // Address taken on strobe fall
    always @(negedge pins.we_n) begin
        key = int'({die, pins.addr});
        t_fall = $realtime;
    end
    // Data taken on strobe rise; short glitches and inhibited writes ignored
    always @(posedge pins.we_n)
        if (sel && pins.oe_n && pins.write_protect_reset_n && $realtime - t_fall > 20) begin
            if (pins.addr == A_5555 && pins.dout == D_20) prot = 1'b0;
            if (pins.addr == A_5555 && pins.dout == 8'ha0) {unl, prot} = 2'b11;
            if (!seq && (!prot || unl)) begin
                pg[key] = pins.dout;
                last_d = pins.dout;
                busy = 1'b1;
            end
            t_last = $realtime;
        end
    // Program the loaded bytes once strobes rest 105 us, done well inside 10 ms
    always #1000 if (busy && $realtime - t_last > 105000) begin
        foreach (pg[k]) mem[k] = pg[k];
        pg.delete();
        {busy, unl} = 2'b00;
    end
    // Reset pin low abandons programming
    always @(negedge pins.write_protect_reset_n) begin
        pg.delete();
        busy = 1'b0;
    end
    // Read path: inverted bit 7 while busy, floating when not read
    assign dq = (sel && !pins.oe_n && pins.we_n && pins.write_protect_reset_n)
              ? (busy ? {~last_d[7], 7'h0} : mem[int'({die, pins.addr})]) : junk;
endmodule

// [sim/ewp_monitor.sv]
// Concurrent checks on the controller's memory-side pins
`timescale 1ns/1ps
module ewp_monitor (
    input wire logic                 hclk,        // Bus clock
    input wire logic                 hresetn,     // Async reset, active low
    input wire ewp_pkg::ewp_pin_type pins,        // Memory-side pins
    input wire logic                 rdy_busy_in  // Busy line, low while busy
);
    import ewp_pkg::*;
    logic [4:0]  gap_r;
    logic [11:0] rp_r;
    // Saturating counts since the last strobe fall and since the reset pin rose
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_r <= 5'h1f;
            rp_r  <= 12'h0;
        end else begin
            gap_r <= $fell(pins.we_n) ? 5'h0 : gap_r + 5'(gap_r != 5'h1f);
            rp_r  <= !pins.write_protect_reset_n ? 12'h0 : rp_r + 12'(rp_r != 12'hfff);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_one_die; $countones(~pins.die_select_n) <= 1; endproperty
    a_one_die: assert property (p_one_die) else $error("two dies selected");
    property p_rw_excl; !pins.we_n |-> pins.oe_n && pins.doe == 8'hff; endproperty
    a_rw_excl: assert property (p_rw_excl) else $error("strobe with oe or undriven");
    property p_strobe; $fell(pins.we_n) |-> !pins.we_n [*7] ##1 pins.we_n; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe width wrong");
    property p_addr; !pins.we_n |-> $stable(pins.addr) && $stable(pins.die_select_n); endproperty
    a_addr: assert property (p_addr) else $error("address moved in strobe");
    property p_latch; $rose(pins.we_n) |-> (pins.doe == 8'hff && $stable(pins.dout)) [*8];
    endproperty
    a_latch: assert property (p_latch) else $error("data latch time short");
    property p_spacing; $fell(pins.we_n) |-> gap_r >= 5'h12; endproperty
    a_spacing: assert property (p_spacing) else $error("byte loads too close");
    property p_res_quiet; !pins.write_protect_reset_n |-> pins.we_n && pins.oe_n; endproperty
    a_res_quiet: assert property (p_res_quiet) else $error("access with reset pin low");
    property p_rp_wait; $fell(pins.we_n) |-> rp_r >= 12'hf9f; endproperty
    a_rp_wait: assert property (p_rp_wait) else $error("write too soon after reset pin");
    // Main scenarios reached
    c_write: cover property ($fell(pins.we_n));
    c_read: cover property ($fell(pins.oe_n));
    c_busy: cover property ($fell(rdy_busy_in));
endmodule
